// *** common/wdr_pkg.sv ***
// package for the watchdog block: register map, fields, reset values, states
package wdr_pkg;
    localparam logic [7:0]  LOAD_OFS    = 8'h00;
    localparam logic [7:0]  VALUE_OFS   = 8'h04;
    localparam logic [7:0]  CTRL_OFS    = 8'h08;
    localparam logic [7:0]  ICLR_OFS    = 8'h0C;
    localparam logic [7:0]  RIS_OFS     = 8'h10;
    localparam logic [7:0]  LOCK_OFS    = 8'h14;
    localparam logic [7:0]  STAT_OFS    = 8'h18;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_RESEN_BIT = 1;
    localparam int          CTRL_STALL_BIT = 2;
    localparam int          STAT_RUN_BIT   = 0;
    localparam int          STAT_LOCK_BIT  = 1;
    localparam logic [31:0] UNLOCK_KEY  = 32'h1ACC_E551;
    localparam logic [31:0] LOAD_RESET  = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
    localparam logic [31:0] ONE_WORD    = 32'h0000_0001;

    typedef enum logic [1:0] {
        WDR_IDLE  = 2'b00,
        WDR_FIRST = 2'b01,
        WDR_SECND = 2'b11
    } wdr_state_t;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
    } wdr_wr_t;
endpackage

// *** design/wdr_regbank.sv ***
// ahb-lite slave front end: captures address phase, issues one-cycle write strobe
`timescale 1ns/1ps
`default_nettype none
module wdr_regbank (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output wdr_pkg::wdr_wr_t wr_o,
    output logic [7:0]       rd_addr_o,
    output logic             rd_o
);
    logic       wr_pend_reg;
    logic       rd_pend_reg;
    logic [7:0] addr_reg;
    logic       take;

    assign take = hsel_i && hready_i && htrans_i[1];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= take && hwrite_i;
            rd_pend_reg <= take && !hwrite_i;
            if (take)
                addr_reg <= haddr_i[7:0];
        end
    end

    // data phase is always zero wait state
    // one driver for the whole strobe bundle
    assign wr_o      = '{wr: wr_pend_reg, addr: addr_reg, data: hwdata_i};
    assign rd_addr_o = haddr_i[7:0];
    assign rd_o      = take && !hwrite_i;
endmodule
`default_nettype wire

// *** design/wdr_top.sv ***
// watchdog with second-timeout reset, lock, live count and debug freeze
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wdr_top (
    input  wire logic        MCLK_I,
    input  wire logic        RESET_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    input  wire logic        DEBUG_HALT_I,
    output logic [31:0]      HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic             WD_IRQ_O,
    output logic             WD_SYS_RESET_O
);
    wdr_pkg::wdr_wr_t    wr;
    logic [7:0]          rd_addr;
    logic                rd;
    logic [31:0]         load_reg;
    logic [31:0]         count_reg;
    logic                run_reg;
    logic                resen_reg;
    logic                stall_reg;
    logic                lock_reg;
    logic                ris_reg;
    logic                rst_reg;
    wdr_pkg::wdr_state_t state_reg;
    logic [31:0]         rdata_reg;
    logic                cfg_wr;
    logic                ctrl_wr;
    logic                load_wr;
    logic                clr_wr;
    logic                tick;
    logic                hit_zero;

    wdr_regbank u_bank (
        .clk_i     (MCLK_I),
        .rst_i     (RESET_I),
        .hsel_i    (HSEL_I),
        .haddr_i   (HADDR_I),
        .htrans_i  (HTRANS_I),
        .hwrite_i  (HWRITE_I),
        .hwdata_i  (HWDATA_I),
        .hready_i  (HREADY_I),
        .wr_o      (wr),
        .rd_addr_o (rd_addr),
        .rd_o      (rd)
    );

    assign cfg_wr  = wr.wr && !lock_reg;
    assign ctrl_wr = cfg_wr && (wr.addr == wdr_pkg::CTRL_OFS);
    assign load_wr = cfg_wr && (wr.addr == wdr_pkg::LOAD_OFS);
    assign clr_wr  = cfg_wr && (wr.addr == wdr_pkg::ICLR_OFS);
    // freeze only counts when enabled; otherwise halt is ignored
    assign tick     = run_reg && !(stall_reg && DEBUG_HALT_I);
    assign hit_zero = tick && (count_reg == wdr_pkg::ONE_WORD || count_reg == wdr_pkg::ZERO_WORD);

    // control bits; run is sticky once enabled, like a real watchdog
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            run_reg   <= 1'b0;
            resen_reg <= 1'b0;
            stall_reg <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            run_reg   <= run_reg | wr.data[wdr_pkg::CTRL_EN_BIT];
            resen_reg <= wr.data[wdr_pkg::CTRL_RESEN_BIT];
            stall_reg <= wr.data[wdr_pkg::CTRL_STALL_BIT];
        end
    end

    // lock engages on any non-key write to the lock register, releases on the key
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
            lock_reg <= 1'b0;
        else if (wr.wr && wr.addr == wdr_pkg::LOCK_OFS)
            lock_reg <= (wr.data != wdr_pkg::UNLOCK_KEY);
    end

    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
            load_reg <= wdr_pkg::LOAD_RESET;
        else if (load_wr)
            load_reg <= wr.data;
    end

    // counter: reads never touch it
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
            count_reg <= wdr_pkg::LOAD_RESET;
        else if (load_wr)
            count_reg <= wr.data;
        else if (ctrl_wr && !run_reg && wr.data[wdr_pkg::CTRL_EN_BIT])
            count_reg <= load_reg;
        else if (hit_zero)
            count_reg <= load_reg;
        else if (tick)
            count_reg <= count_reg - wdr_pkg::ONE_WORD;
    end

    // interrupt flag: set wins over clear
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
            ris_reg <= 1'b0;
        else if (hit_zero || (load_wr && run_reg && wr.data == wdr_pkg::ZERO_WORD))
            ris_reg <= 1'b1;
        else if (clr_wr)
            ris_reg <= 1'b0;
    end

    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
            state_reg <= wdr_pkg::WDR_IDLE;
        else
        begin
            case (state_reg)
                wdr_pkg::WDR_IDLE:
                    if (run_reg)
                        state_reg <= wdr_pkg::WDR_FIRST;
                wdr_pkg::WDR_FIRST:
                    if (hit_zero && ris_reg && resen_reg)
                        state_reg <= wdr_pkg::WDR_SECND;
                wdr_pkg::WDR_SECND:
                    state_reg <= wdr_pkg::WDR_SECND;
                default:
                    state_reg <= wdr_pkg::WDR_IDLE;
            endcase
        end
    end

    // reset output held until system reset
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
            rst_reg <= 1'b0;
        else if (state_reg == wdr_pkg::WDR_FIRST && hit_zero && ris_reg && resen_reg)
            rst_reg <= 1'b1;
    end

    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
            rdata_reg <= wdr_pkg::ZERO_WORD;
        else if (rd)
        begin
            case (rd_addr)
                wdr_pkg::LOAD_OFS:  rdata_reg <= load_reg;
                wdr_pkg::VALUE_OFS: rdata_reg <= count_reg;
                wdr_pkg::CTRL_OFS:  rdata_reg <= {29'h000_0000, stall_reg, resen_reg, run_reg};
                wdr_pkg::RIS_OFS:   rdata_reg <= {31'h000_0000, ris_reg};
                wdr_pkg::LOCK_OFS:  rdata_reg <= {31'h000_0000, lock_reg};
                wdr_pkg::STAT_OFS:  rdata_reg <= {30'h000_0000, lock_reg, run_reg};
                default:            rdata_reg <= wdr_pkg::ZERO_WORD;
            endcase
        end
    end

    assign HRDATA_O       = rdata_reg;
    assign HREADYOUT_O    = 1'b1;
    assign HRESP_O        = 1'b0;
    assign WD_IRQ_O       = ris_reg;
    assign WD_SYS_RESET_O = rst_reg;

    // building blocks for the checks below
    sequence first_expiry_s;
        hit_zero && !ris_reg;
    endsequence

    sequence second_expiry_s;
        state_reg == wdr_pkg::WDR_FIRST && hit_zero && ris_reg && resen_reg;
    endsequence

    sequence zero_load_s;
        load_wr && run_reg && wr.data == wdr_pkg::ZERO_WORD;
    endsequence

    sequence locked_cfg_write_s;
        wr.wr && lock_reg && (wr.addr == wdr_pkg::LOAD_OFS || wr.addr == wdr_pkg::CTRL_OFS);
    endsequence

    sequence enable_write_s;
        ctrl_wr && !run_reg && wr.data[wdr_pkg::CTRL_EN_BIT];
    endsequence

    sequence frozen_halt_s;
        stall_reg && DEBUG_HALT_I && !wr.wr;
    endsequence

    sequence value_read_s;
        rd && rd_addr == wdr_pkg::VALUE_OFS;
    endsequence

    sequence status_read_s;
        rd && rd_addr == wdr_pkg::STAT_OFS;
    endsequence

    lock_blocks_ctrl_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (wr.wr && lock_reg && wr.addr == wdr_pkg::CTRL_OFS) |=> $stable(resen_reg))
        else $error("reset enable changed while locked");
    freeze_holds_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (stall_reg && DEBUG_HALT_I && !wr.wr) |=> $stable(count_reg))
        else $error("count moved during frozen halt");
    free_counts_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (run_reg && !stall_reg && !wr.wr && count_reg > wdr_pkg::ONE_WORD) |=>
        count_reg == $past(count_reg) - wdr_pkg::ONE_WORD)
        else $error("count did not decrement");
    no_reset_off_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (!resen_reg && !rst_reg) |=> !rst_reg)
        else $error("reset issued while disabled");
    reload_zero_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (hit_zero && !wr.wr) |=> (count_reg == $past(load_reg) && ris_reg))
        else $error("no reload at zero");
    load_write_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        load_wr |=> count_reg == $past(wr.data))
        else $error("load not copied to counter");
    unlock_key_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (wr.wr && wr.addr == wdr_pkg::LOCK_OFS && wr.data == wdr_pkg::UNLOCK_KEY) |=> !lock_reg)
        else $error("unlock failed");
    second_reset_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (state_reg == wdr_pkg::WDR_FIRST && hit_zero && ris_reg && resen_reg) |=> rst_reg)
        else $error("second timeout gave no reset");

    // register-side and counter-side guards, some built from the sequences above
    locked_cfg_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        locked_cfg_write_s |=>
        ($stable(load_reg) && $stable(stall_reg) && $stable(resen_reg) && $stable(run_reg)))
        else $error("config changed while locked");
    locked_count_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (wr.wr && lock_reg && wr.addr == wdr_pkg::LOAD_OFS && !tick) |=>
        $stable(count_reg))
        else $error("locked load reached the counter");
    lock_engage_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (wr.wr && wr.addr == wdr_pkg::LOCK_OFS && wr.data != wdr_pkg::UNLOCK_KEY) |=>
        lock_reg)
        else $error("lock did not engage");
    status_read_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        status_read_s |=>
        (HRDATA_O[wdr_pkg::STAT_RUN_BIT] == $past(run_reg) &&
        HRDATA_O[wdr_pkg::STAT_LOCK_BIT] == $past(lock_reg)))
        else $error("status read wrong");
    run_sticky_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        run_reg |=>
        run_reg)
        else $error("running status dropped");
    value_read_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        value_read_s |=>
        HRDATA_O == $past(count_reg))
        else $error("live count read wrong");
    read_quiet_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (rd && !wr.wr && !tick) |=>
        $stable(count_reg))
        else $error("read disturbed the count");
    zero_load_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        zero_load_s |=>
        (ris_reg && count_reg == wdr_pkg::ZERO_WORD))
        else $error("zero reload gave no interrupt");
    enable_copy_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        enable_write_s |=>
        (run_reg && count_reg == $past(load_reg)))
        else $error("enable did not load the counter");
    first_irq_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        first_expiry_s |=>
        ris_reg)
        else $error("first timeout gave no interrupt");
    first_no_reset_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        first_expiry_s |=>
        $stable(rst_reg))
        else $error("first timeout touched the reset");
    reload_count_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        first_expiry_s ##1 (tick && !wr.wr && count_reg > wdr_pkg::ONE_WORD) |=>
        count_reg == $past(count_reg) - wdr_pkg::ONE_WORD)
        else $error("no count after reload");
    irq_holds_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (ris_reg && !clr_wr) |=>
        ris_reg)
        else $error("interrupt dropped uncleared");
    irq_clear_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        (clr_wr && !hit_zero) |=>
        !ris_reg)
        else $error("interrupt clear ignored");
    reset_sticky_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        rst_reg |=>
        rst_reg)
        else $error("reset request dropped");
    second_state_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        second_expiry_s |=>
        state_reg == wdr_pkg::WDR_SECND)
        else $error("second timeout not recorded");
    frozen_irq_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        frozen_halt_s |=>
        ($stable(ris_reg) && $stable(rst_reg)))
        else $error("timeout during frozen halt");
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the watchdog: ahb tasks, register model, timing checks
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        mclk_i = 1'h0, reset_i = 1'h1, hsel_i = 1'h0, hwrite_i = 1'h0, halt_i = 1'h0;
    logic [31:0] haddr_i = 32'h0000_0000, hwdata_i = 32'h0000_0000, hrdata_o, m_load, v1, q;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic [2:0]  m_ctrl;
    logic        hreadyout_o, hresp_o, irq_o, srst_o, m_lock;
    int          err_count = 0, total_checks = 0, cyc = 0, ta, t1, n, L, h;

    always #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) cyc <= cyc + 1;

    wdr_top wdr_top_inst (.MCLK_I(mclk_i), .RESET_I(reset_i), .HSEL_I(hsel_i), .HADDR_I(haddr_i),
        .HTRANS_I(htrans_i), .HWRITE_I(hwrite_i), .HSIZE_I(hsize_i), .HWDATA_I(hwdata_i),
        .HREADY_I(hreadyout_o), .DEBUG_HALT_I(halt_i), .HRDATA_O(hrdata_o), .HREADYOUT_O(hreadyout_o),
        .HRESP_O(hresp_o), .WD_IRQ_O(irq_o), .WD_SYS_RESET_O(srst_o));

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    // every phase waits for hready, never a fixed count
    task automatic rdy;
        int k;
        for (k = 0; k < 20; k++)
        begin
            @(posedge mclk_i);
            if (hreadyout_o === 1'h1) break;
        end
        if (k == 20)
        begin
            err_count++;
            close_out;
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_i <= 1'h1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {24'h00_0000, a};
        rdy;
        ta = cyc;
        hsel_i <= 1'h0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        rdy;
        q = hrdata_o;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
        if (a == wdr_pkg::LOAD_OFS && !m_lock) m_load = d;
        if (a == wdr_pkg::CTRL_OFS && !m_lock) m_ctrl = {d[2:1], m_ctrl[0] | d[0]};
        if (a == wdr_pkg::LOCK_OFS) m_lock = (d !== wdr_pkg::UNLOCK_KEY);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'h0, a, 32'h0000_0000);
    endtask

    // c is the edge count at which the flag was first seen, 0 if never
    task automatic wt(input bit s, input int b, input bit must, output int c);
        int k;
        for (k = 0; k < b; k++)
        begin
            @(posedge mclk_i);
            if ((s ? srst_o : irq_o) === 1'h1) break;
        end
        c = (k < b) ? k + 1 : 0;
        if (must && c == 0)
        begin
            err_count++;
            close_out;
        end
    endtask

    task automatic rst;
        reset_i <= 1'h1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'h0;
        m_load = wdr_pkg::LOAD_RESET;
        m_ctrl = 3'h0;
        m_lock = 1'h0;
    endtask

    initial
    begin
        void'($urandom(88));
        rst;
        rd(wdr_pkg::LOAD_OFS); chk("load", m_load, q);
        rd(wdr_pkg::STAT_OFS); chk("status", 32'h0000_0000, q);
        rd(8'h40); chk("unmapped", 32'h0000_0000, q);
        chk("irq", 32'h0000_0000, {31'h0, irq_o});
        $display("test reset values done");
        L = 20 + $urandom % 20;
        wr(wdr_pkg::LOAD_OFS, L);
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0002);
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0000);
        rd(wdr_pkg::CTRL_OFS); chk("reset off", {29'h0, m_ctrl}, q);
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0001);
        wt(1'b0, L + 4, 1'b1, n); chk("first timeout", L + 1, n);
        rd(wdr_pkg::RIS_OFS); chk("raw irq", 32'h0000_0001, q);
        rd(wdr_pkg::STAT_OFS); chk("running", {30'h0, m_lock, m_ctrl[0]}, q);
        wt(1'b1, L + 6, 1'b0, n); chk("no reset", 32'h0000_0000, n);
        $display("test timeout without reset done");
        wr(wdr_pkg::ICLR_OFS, 32'h0000_0001);
        @(posedge mclk_i); chk("irq cleared", 32'h0000_0000, {31'h0, irq_o});
        wr(wdr_pkg::LOAD_OFS, 32'h0001_0000);
        rd(wdr_pkg::VALUE_OFS); v1 = q; t1 = ta;
        chk("reload copy", 32'h0001_0000, v1);
        rd(wdr_pkg::VALUE_OFS); chk("live count", v1 - (ta - t1), q);
        h = 10 + $urandom % 40;
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0005);
        halt_i <= 1'h1;
        rd(wdr_pkg::VALUE_OFS); v1 = q;
        repeat (h) @(posedge mclk_i);
        rd(wdr_pkg::VALUE_OFS); chk("frozen", v1, q);
        halt_i <= 1'h0;
        rd(wdr_pkg::VALUE_OFS); v1 = q; t1 = ta;
        rd(wdr_pkg::VALUE_OFS); chk("resumed", v1 - (ta - t1), q);
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0001);
        halt_i <= 1'h1;
        rd(wdr_pkg::VALUE_OFS); v1 = q; t1 = ta;
        rd(wdr_pkg::VALUE_OFS); chk("no freeze", v1 - (ta - t1), q);
        halt_i <= 1'h0;
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0005);
        wr(wdr_pkg::LOAD_OFS, L);
        repeat (5) @(posedge mclk_i);
        halt_i <= 1'h1;
        repeat (h) @(posedge mclk_i);
        halt_i <= 1'h0;
        wt(1'b0, L + 4, 1'b1, n); chk("held expiry", L + 1 + h, n + 5 + h);
        $display("test live count and freeze done");
        wr(wdr_pkg::LOCK_OFS, 32'h0000_0000);
        rd(wdr_pkg::STAT_OFS); chk("locked", {30'h0, m_lock, m_ctrl[0]}, q);
        rd(wdr_pkg::LOCK_OFS); chk("lock state", {31'h0, m_lock}, q);
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0007);
        rd(wdr_pkg::CTRL_OFS); chk("ctrl locked", {29'h0, m_ctrl}, q);
        wr(wdr_pkg::LOAD_OFS, 32'h0000_0005);
        rd(wdr_pkg::LOAD_OFS); chk("load locked", m_load, q);
        wr(wdr_pkg::LOCK_OFS, wdr_pkg::UNLOCK_KEY);
        rd(wdr_pkg::STAT_OFS); chk("unlocked", {30'h0, m_lock, m_ctrl[0]}, q);
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0003);
        rd(wdr_pkg::CTRL_OFS); chk("ctrl open", {29'h0, m_ctrl}, q);
        $display("test lock done");
        rst;
        wr(wdr_pkg::LOAD_OFS, L);
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0003);
        wt(1'b0, L + 4, 1'b1, n);
        wr(wdr_pkg::ICLR_OFS, 32'h0000_0001);
        wt(1'b1, L + 2, 1'b0, n); chk("cleared no reset", 32'h0000_0000, n);
        wt(1'b1, L + 4, 1'b1, n);
        repeat (3) @(posedge mclk_i);
        chk("reset held", 32'h0000_0001, {31'h0, srst_o});
        rst;
        wr(wdr_pkg::CTRL_OFS, 32'h0000_0001);
        wr(wdr_pkg::LOAD_OFS, 32'h0000_0000);
        wt(1'b0, 3, 1'b1, n); chk("zero reload", 32'h0000_0001, {31'h0, irq_o});
        chk("hresp", 32'h0000_0000, {31'h0, hresp_o});
        $display("test reset and zero reload done");
        close_out;
    end
endmodule
`default_nettype wire
